// ===== hdl/disc_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "disc_if_params.svh"
module disc_if #(
    parameter int ONESHOT_CYCLES = `ONESHOT_CYCLES,
    parameter int SECTORS = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] unit_sel,
    input wire logic unit_en,
    input wire logic step_req,
    input wire logic step_inward,
    input wire logic [6:0] track_pos,
    input wire logic oneshot_trigger,
    input wire logic oneshot_clear_n,
    input wire logic power_alarm_n,
    input wire logic write_req,
    input wire logic sector_found_clear_n,
    input wire logic [4:0] target_sector,
    input wire logic preamble_sync_enable,
    input wire logic pll_input_select,
    input wire logic tx_data,
    input wire logic irq_mask_in,
    input wire logic sector_pulse_n,
    input wire logic index_pulse_n,
    input wire logic medium_protected_n,
    input wire logic head_at_outer_n,
    input wire logic medium_changed_n,
    input wire logic drive_ready_n,
    input wire logic raw_read_n,
    output logic drive_select0_n,
    output logic drive_select1_n,
    output logic drive_select2_n,
    output logic drive_select3_n,
    output logic step_n,
    output logic dir_out_n,
    output logic step_busy,
    output logic inner_track_precomp_n,
    output logic oneshot_expired_n,
    output logic write_enable_n,
    output logic write_data_n,
    output logic sector_found,
    output logic [4:0] sector_count,
    output logic preamble_synced,
    output logic codec_clock,
    output logic codec_clock_inv,
    output logic pll_data,
    output logic raw_read_inv,
    output logic irq_gate,
    output logic status_ready,
    output logic status_track0,
    output logic status_protected,
    output logic status_changed
);

    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] sel;
    logic [7:0] step_cnt;
    disc_if_pkg::step_state_t step_state;

    // Selects only change while no step is in flight, so a pulse never hits two drives.
    always_ff @(posedge clk) begin
        if (srst) begin
            sel <= 4'h0;
        end else if (step_state == disc_if_pkg::STEP_IDLE) begin
            sel <= unit_en ? (4'h1 << unit_sel) : 4'h0;
        end
    end

    assign drive_select0_n = ~sel[0];
    assign drive_select1_n = ~sel[1];
    assign drive_select2_n = ~sel[2];
    assign drive_select3_n = ~sel[3];

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (srst) begin
            step_state <= disc_if_pkg::STEP_IDLE;
            step_cnt <= 8'h00;
            step_n <= 1'b1;
            dir_out_n <= 1'b1;
        end else begin
            unique case (step_state)
                disc_if_pkg::STEP_IDLE: begin
                    step_n <= 1'b1;
                    if (step_req && unit_en) begin
                        dir_out_n <= ~step_inward;
                        step_cnt <= 8'(`DIR_SETUP_CYCLES - 1);
                        step_state <= disc_if_pkg::STEP_SETUP;
                    end
                end
                disc_if_pkg::STEP_SETUP: begin
                    // Direction settles before the pulse starts.
                    if (step_cnt == 8'h00) begin
                        step_n <= 1'b0;
                        step_cnt <= 8'(`STEP_PULSE_CYCLES - 1);
                        step_state <= disc_if_pkg::STEP_PULSE;
                    end else begin
                        step_cnt <= step_cnt - 8'h01;
                    end
                end
                disc_if_pkg::STEP_PULSE: begin
                    if (step_cnt == 8'h00) begin
                        step_n <= 1'b1;
                        step_cnt <= 8'(`DIR_SETUP_CYCLES - 1);
                        step_state <= disc_if_pkg::STEP_HOLD;
                    end else begin
                        step_cnt <= step_cnt - 8'h01;
                    end
                end
                disc_if_pkg::STEP_HOLD: begin
                    // Direction is kept after the pulse too, for the drive's hold time.
                    if (step_cnt == 8'h00) begin
                        step_state <= disc_if_pkg::STEP_IDLE;
                    end else begin
                        step_cnt <= step_cnt - 8'h01;
                    end
                end
            endcase
        end
    end

    assign step_busy = (step_state != disc_if_pkg::STEP_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (srst) begin
            inner_track_precomp_n <= 1'b1;
        end else begin
            inner_track_precomp_n <= ~(track_pos > 7'(`PRECOMP_TRACK));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [23:0] os_cnt;
    logic os_run;

    always_ff @(posedge clk) begin
        if (srst || !oneshot_clear_n) begin
            os_cnt <= 24'h000000;
            os_run <= 1'b0;
            oneshot_expired_n <= 1'b1;
        end else if (oneshot_trigger) begin
            os_cnt <= 24'(ONESHOT_CYCLES - 1);
            os_run <= 1'b1;
            oneshot_expired_n <= 1'b1;
        end else if (os_run) begin
            if (os_cnt == 24'h000000) begin
                os_run <= 1'b0;
                oneshot_expired_n <= 1'b0;
            end else begin
                os_cnt <= os_cnt - 24'h000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic writing;

    // A write already running finishes under alarm; only a new start is refused.
    always_ff @(posedge clk) begin
        if (srst) begin
            writing <= 1'b0;
        end else if (!write_req || !unit_en) begin
            writing <= 1'b0;
        end else if (!writing && power_alarm_n && medium_protected_n) begin
            writing <= 1'b1;
        end
    end

    assign write_enable_n = ~writing;

    ////////////////////////////////////////////////////////////////////////////
    logic [5:0] cdiv;
    logic cclk;
    logic cclk_q;
    logic cell_tick;

    always_ff @(posedge clk) begin
        if (srst) begin
            cdiv <= 6'h00;
            cclk <= 1'b0;
        end else if (cdiv == 6'(`CODEC_HALF_CYCLES - 1)) begin
            cdiv <= 6'h00;
            cclk <= ~cclk;
        end else begin
            cdiv <= cdiv + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cclk_q <= 1'b0;
        end else begin
            cclk_q <= cclk;
        end
    end

    assign cell_tick = cclk & ~cclk_q;
    assign codec_clock = cclk;
    assign codec_clock_inv = ~cclk;

    // Frequency modulation: a clock mark every cell, a data mark mid-cell for a one.
    logic fm_bit;
    always_ff @(posedge clk) begin
        if (srst) begin
            write_data_n <= 1'b1;
            fm_bit <= 1'b0;
        end else begin
            if (cell_tick) begin
                fm_bit <= tx_data;
            end
            if (!writing) begin
                write_data_n <= 1'b1;
            end else if (cell_tick) begin
                write_data_n <= 1'b0;
            end else if (cdiv == 6'h00 && !cclk && fm_bit) begin
                write_data_n <= 1'b0;
            end else begin
                write_data_n <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (srst) begin
            raw_read_inv <= 1'b0;
            pll_data <= 1'b0;
        end else begin
            raw_read_inv <= ~raw_read_n;
            pll_data <= pll_input_select ? ~write_data_n : raw_read_inv;
        end
    end

    // Count read transitions per cell; cells with only the clock mark are zeros.
    logic rd_q;
    logic [1:0] edges;
    logic [4:0] zero_run;
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_q <= 1'b0;
            edges <= 2'h0;
            zero_run <= 5'h00;
            preamble_synced <= 1'b0;
        end else begin
            rd_q <= raw_read_inv;
            if (!preamble_sync_enable) begin
                edges <= 2'h0;
                zero_run <= 5'h00;
                preamble_synced <= 1'b0;
            end else if (cell_tick) begin
                edges <= {1'b0, raw_read_inv & ~rd_q};
                if (edges == 2'h1) begin
                    if (zero_run == 5'(`SYNC_ZERO_CELLS - 1)) begin
                        preamble_synced <= 1'b1;
                    end else begin
                        zero_run <= zero_run + 5'h01;
                    end
                end else begin
                    zero_run <= 5'h00;
                end
            end else if (raw_read_inv && !rd_q && edges != 2'h3) begin
                edges <= edges + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic sect_q;
    logic idx_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            sect_q <= 1'b1;
            idx_q <= 1'b1;
            sector_count <= 5'h00;
        end else begin
            sect_q <= sector_pulse_n;
            idx_q <= index_pulse_n;
            // Index wins: it marks sector zero even if a sector pulse coincides.
            if (!index_pulse_n && idx_q) begin
                sector_count <= 5'h00;
            end else if (!sector_pulse_n && sect_q) begin
                sector_count <= (sector_count == 5'(SECTORS - 1)) ? 5'h00 :
                    sector_count + 5'h01;
            end
        end
    end

    // A match in the clearing cycle still sets the flag.
    always_ff @(posedge clk) begin
        if (srst) begin
            sector_found <= 1'b0;
        end else if (sector_count == target_sector && !sector_pulse_n && sect_q) begin
            sector_found <= 1'b1;
        end else if (!sector_found_clear_n) begin
            sector_found <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_gate <= 1'b0;
            status_ready <= 1'b0;
            status_track0 <= 1'b0;
            status_protected <= 1'b0;
            status_changed <= 1'b0;
        end else begin
            irq_gate <= irq_mask_in;
            status_ready <= ~drive_ready_n;
            status_track0 <= ~head_at_outer_n;
            status_protected <= ~medium_protected_n;
            status_changed <= ~medium_changed_n;
        end
    end

endmodule
`default_nettype wire

// ===== hdl/disc_if_params.svh
// Functional notes
// - One of four active-low drive selects.
// - Step pulse with direction moves one track.
// - Direction output picks inward or outward.
// - Precompensation enabled only above track 41.
// - Trigger starts a 10 ms one-shot.
// - Expiry asserts timed-out indication.
// - Active-low clear resets one-shot and flag.
// - Power alarm blocks starting new writes.
// - Active-low write enable gates drive recording.
// - Sector-found flop cleared by active-low line.
// - Sync decoder locks on preamble zero stream.
// - Codec timed by 500 kHz clock, complemented.
// - Transmit data encoded into write stream.
// - Select line picks the PLL input source.
// - Index and sector pulses locate the sector.
// - Mask output gates the processor interrupt.
// - Raw read data buffered and inverted.
`ifndef DISC_IF_PARAMS_SVH
`define DISC_IF_PARAMS_SVH
`define CLK_HZ 20000000
`define ONESHOT_MS 10
`define ONESHOT_CYCLES ((`CLK_HZ / 1000) * `ONESHOT_MS)
`define CODEC_HZ 500000
`define CODEC_HALF_CYCLES (`CLK_HZ / (2 * `CODEC_HZ))
`define PRECOMP_TRACK 41
`define STEP_PULSE_CYCLES 20
`define DIR_SETUP_CYCLES 20
`define SYNC_ZERO_CELLS 16
`endif

// ===== hdl/disc_if_pkg.sv
package disc_if_pkg;
    typedef enum logic [1:0] {
        STEP_IDLE,
        STEP_SETUP,
        STEP_PULSE,
        STEP_HOLD
    } step_state_t;
endpackage

// ===== testbench/disc_if_checker.sv
`timescale 1ns/1ps
`default_nettype none
module disc_if_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic [6:0] track_pos,
    input wire logic raw_read_n,
    input wire logic oneshot_clear_n,
    input wire logic write_req,
    input wire logic power_alarm_n,
    input wire logic medium_protected_n,
    input wire logic drive_select0_n,
    input wire logic drive_select1_n,
    input wire logic drive_select2_n,
    input wire logic drive_select3_n,
    input wire logic step_n,
    input wire logic dir_out_n,
    input wire logic step_busy,
    input wire logic inner_track_precomp_n,
    input wire logic oneshot_expired_n,
    input wire logic write_enable_n,
    input wire logic raw_read_inv
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire [3:0] sel_n = {drive_select3_n, drive_select2_n, drive_select1_n, drive_select0_n};
    logic [5:0] low_cnt;
    always_ff @(posedge clk) begin
        if (srst || step_n) begin
            low_cnt <= 6'h0;
        end else begin
            low_cnt <= low_cnt + 6'h1;
        end
    end
    sel_onehot_a: assert property ($countones(~sel_n) <= 1)
        else $error("two drives selected");
    sel_frozen_a: assert property (step_busy && $past(step_busy) |-> $stable(sel_n))
        else $error("select moved during step");
    step_width_a: assert property ($rose(step_n) |-> low_cnt == 6'h14)
        else $error("step pulse width wrong");
    step_delay_a: assert property ($rose(step_busy) |-> ##[18:22] $fell(step_n))
        else $error("step pulse late");
    dir_hold_a: assert property (step_busy && $past(step_busy) |-> $stable(dir_out_n))
        else $error("direction moved during step");
    precomp_a: assert property (!$past(srst) |->
        inner_track_precomp_n == ($past(track_pos) <= 7'h29))
        else $error("precomp wrong");
    os_clear_a: assert property (!oneshot_clear_n |=> oneshot_expired_n)
        else $error("one-shot not cleared");
    alarm_block_a: assert property ($fell(write_enable_n) |->
        $past(power_alarm_n) && $past(medium_protected_n))
        else $error("write started while blocked");
    wr_stop_a: assert property (!write_req |=> write_enable_n)
        else $error("write enable stayed on");
    raw_inv_a: assert property (!$past(srst) |-> raw_read_inv == !$past(raw_read_n))
        else $error("raw data not inverted");
endmodule
bind disc_if disc_if_checker chk (.*);
`default_nettype wire

// ===== testbench/drive_unit_model.sv
`timescale 1ns/1ps
`default_nettype none
module drive_unit_model #(
    parameter int GAP = 20,
    parameter int NSEC = 8,
    parameter int CELL = 40
) (
    input wire logic clk,
    input wire logic sel_n,
    input wire logic step_n,
    input wire logic dir_out_n,
    input wire logic protect,
    input wire logic changed,
    output logic sector_pulse_n,
    output logic index_pulse_n,
    output logic head_at_outer_n,
    output logic medium_protected_n,
    output logic medium_changed_n,
    output logic drive_ready_n,
    output logic raw_read_n
);
    int cyc = 0;
    int track = 0;
    logic step_d = 1'b1;
    // The head moves on the leading edge of the step pulse only.
    always @(posedge clk) begin
        cyc <= (cyc + 1) % (GAP * NSEC);
        step_d <= step_n;
        if (!step_n && step_d && !sel_n) begin
            track <= dir_out_n ? ((track > 0) ? track - 1 : 0) : track + 1;
        end
    end
    assign sector_pulse_n = (cyc % GAP) > 1;
    assign index_pulse_n = cyc > 1;
    assign head_at_outer_n = track != 0;
    assign medium_protected_n = !(protect && !sel_n);
    assign medium_changed_n = !changed;
    assign drive_ready_n = sel_n;
    // A stream of clock marks only, as in a sector preamble.
    // CELL must divide GAP * NSEC, or the stream jumps at the revolution wrap.
    assign raw_read_n = (cyc % CELL) > 3;
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, srst = 1'b1, unit_en = 1'b0, step_req = 1'b0, step_inward = 1'b0;
    logic [1:0] unit_sel = 2'h0;
    logic [6:0] track_pos = 7'h0;
    logic [4:0] target_sector = 5'h3;
    logic oneshot_trigger = 1'b0, oneshot_clear_n = 1'b1, power_alarm_n = 1'b1;
    logic write_req = 1'b0, sector_found_clear_n = 1'b1, preamble_sync_enable = 1'b0;
    logic pll_input_select = 1'b0, tx_data = 1'b1, irq_mask_in = 1'b0;
    logic protect = 1'b0, changed = 1'b0;
    wire logic sector_pulse_n, index_pulse_n, medium_protected_n, head_at_outer_n;
    wire logic medium_changed_n, drive_ready_n, raw_read_n, step_n, dir_out_n;
    wire logic drive_select0_n, drive_select1_n, drive_select2_n, drive_select3_n;
    wire logic step_busy, inner_track_precomp_n, oneshot_expired_n, write_enable_n;
    wire logic write_data_n, sector_found, preamble_synced, codec_clock, codec_clock_inv;
    wire logic pll_data, raw_read_inv, irq_gate, status_ready, status_track0;
    wire logic status_protected, status_changed;
    wire logic [4:0] sector_count;
    wire [3:0] sel_n = {drive_select3_n, drive_select2_n, drive_select1_n, drive_select0_n};
    int error_cnt = 0, checked = 0, n, m, c, k;
    // A short one-shot keeps the run brief; expectations use the same figure.
    disc_if #(.ONESHOT_CYCLES(50)) dut (.*);
    drive_unit_model drv (.sel_n(drive_select0_n), .*);
    initial forever #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watches the write stream, the PLL feed and the codec clocks for a number of cycles.
    // Call it just after a falling edge; the PLL feed is held against its selected source one cycle earlier.
    task automatic watch(input int cycles);
        logic prev_w, prev_r, prev_c;
        n = 0;
        m = 0;
        c = 0;
        k = 0;
        prev_w = write_data_n;
        prev_r = raw_read_inv;
        prev_c = codec_clock;
        repeat (cycles) begin
            @(negedge clk);
            n += int'(write_data_n === 1'b0);
            m += int'(pll_data !== (pll_input_select ? !prev_w : prev_r));
            c += int'(codec_clock === 1'b1 && prev_c === 1'b0);
            k += int'(codec_clock_inv !== !codec_clock);
            prev_w = write_data_n;
            prev_r = raw_read_inv;
            prev_c = codec_clock;
        end
    endtask
    // Request held three cycles: the extra cycles fall while busy and must be ignored.
    task automatic do_step(input logic inward);
        @(posedge clk);
        step_inward <= inward;
        step_req <= 1'b1;
        repeat (3) @(posedge clk);
        step_req <= 1'b0;
        repeat (80) @(negedge clk);
        chk("dir", {7'h0, !inward}, dir_out_n);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("idle", 8'hff, {sel_n, step_n, write_enable_n, oneshot_expired_n, dir_out_n});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            unit_sel <= i[1:0];
            unit_en <= 1'b1;
            repeat (3) @(negedge clk);
            chk("select", 8'h0f & ~(8'h01 << i), {4'h0, sel_n});
            chk("ready", {7'h0, i == 0}, status_ready);
        end
        @(posedge clk);
        unit_sel <= 2'h0;
        repeat (3) @(negedge clk);
        chk("track0", 8'h1, status_track0);
        do_step(1'b1);
        chk("track0", 8'h0, status_track0);
        do_step(1'b0);
        chk("track0", 8'h1, status_track0);
        for (int t = 41; t < 43; t++) begin
            @(posedge clk);
            track_pos <= t[6:0];
            repeat (2) @(negedge clk);
            chk("precomp", {7'h0, t == 41}, inner_track_precomp_n);
        end
        @(posedge clk);
        oneshot_trigger <= 1'b1;
        @(posedge clk);
        oneshot_trigger <= 1'b0;
        repeat (45) @(negedge clk);
        chk("os_early", 8'h1, oneshot_expired_n);
        repeat (10) @(negedge clk);
        chk("os_done", 8'h0, oneshot_expired_n);
        @(posedge clk);
        oneshot_clear_n <= 1'b0;
        @(posedge clk);
        oneshot_clear_n <= 1'b1;
        @(negedge clk);
        chk("os_clear", 8'h1, oneshot_expired_n);
        @(posedge clk);
        power_alarm_n <= 1'b0;
        write_req <= 1'b1;
        repeat (10) @(negedge clk);
        chk("we_alarm", 8'h1, write_enable_n);
        @(posedge clk);
        power_alarm_n <= 1'b1;
        pll_input_select <= 1'b1;
        repeat (10) @(negedge clk);
        chk("we_on", 8'h0, write_enable_n);
        watch(100);
        chk("wdata_one", 8'h5, n[7:0]);
        chk("pll_wr", 8'h0, m[7:0]);
        @(posedge clk);
        tx_data <= 1'b0;
        repeat (45) @(negedge clk);
        watch(120);
        chk("wdata_zero", 8'h3, n[7:0]);
        chk("pll_wr", 8'h0, m[7:0]);
        @(posedge clk);
        write_req <= 1'b0;
        repeat (3) @(negedge clk);
        chk("we_off", 8'h1, write_enable_n);
        @(posedge clk);
        protect <= 1'b1;
        write_req <= 1'b1;
        repeat (10) @(negedge clk);
        chk("we_prot", 8'h3, {write_enable_n, status_protected});
        chk("sync_off", 8'h0, preamble_synced);
        @(posedge clk);
        write_req <= 1'b0;
        protect <= 1'b0;
        changed <= 1'b1;
        irq_mask_in <= 1'b1;
        pll_input_select <= 1'b0;
        preamble_sync_enable <= 1'b1;
        repeat (3) @(negedge clk);
        watch(800);
        chk("codec", 8'h14, c[7:0]);
        chk("clk_inv", 8'h0, k[7:0]);
        chk("wdata_off", 8'h0, n[7:0]);
        chk("pll_rd", 8'h0, m[7:0]);
        chk("sync", 8'h1, preamble_synced);
        chk("chg_irq", 8'h3, {status_changed, irq_gate});
        // Line up on the index so the clear below cannot meet a matching sector pulse.
        do @(negedge clk); while (!index_pulse_n);
        do @(negedge clk); while (index_pulse_n);
        repeat (70) @(negedge clk);
        chk("sec_count", 8'h3, {3'h0, sector_count});
        chk("sector", 8'h1, sector_found);
        @(posedge clk);
        sector_found_clear_n <= 1'b0;
        @(posedge clk);
        sector_found_clear_n <= 1'b1;
        @(negedge clk);
        chk("sec_clear", 8'h0, sector_found);
        repeat (20) @(negedge clk);
        chk("sec_set", 8'h1, sector_found);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
